// ---- eio_pkg.sv ----
package eio_pkg;

    // Time base
    localparam int unsigned CLK_HZ       = 10_000_000;
    localparam int unsigned TICK_MS      = 1;
    localparam int unsigned CYC_PER_TICK = CLK_HZ / 1000 * TICK_MS;

    // Filter response time, ms
    localparam logic [8:0] FILT_MIN_MS = 9'd50;
    localparam logic [8:0] FILT_MAX_MS = 9'd500;
    localparam logic [8:0] FILT_RST_MS = 9'd50;

    // End-of-measurement pulse width, ms
    localparam logic [6:0] PULSE_MIN_MS = 7'd1;
    localparam logic [6:0] PULSE_MAX_MS = 7'd100;
    localparam logic [6:0] PULSE_RST_MS = 7'd5;
    localparam logic [6:0] AUTOCAL_MS   = 7'd5;

    // Register byte offsets
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_FILT   = 8'h04;
    localparam logic [7:0] OFS_PULSE  = 8'h08;
    localparam logic [7:0] OFS_TEST   = 8'h0C;
    localparam logic [7:0] OFS_STATUS = 8'h10;

    // Scan modes
    localparam logic [1:0] SCAN_OFF  = 2'h0;
    localparam logic [1:0] SCAN_AUTO = 2'h1;
    localparam logic [1:0] SCAN_STEP = 2'h2;

    // Control word, most significant field first; filter_en is bit 0
    typedef struct packed {
        logic [1:0] scan_mode;
        logic       sort_en;
        logic       stats_en;
        logic       memory_en;
        logic       term_scanner;
        logic       test_mode;
        logic       autocal;
        logic       measure_trigger_in_ext;
        logic       eom_pulse;
        logic       measure_trigger_in_off_edge;
        logic       filter_en;
    } eio_ctrl_t;

    localparam eio_ctrl_t CTRL_RST = '0;

    typedef enum logic [1:0] {
        EOM_IDLE  = 2'b00,
        EOM_HOLD  = 2'b01,
        EOM_PULSE = 2'b10
    } eio_eom_state_t;

endpackage : eio_pkg

// ---- eio_filter.sv ----
`timescale 1ns/1ps
`default_nettype none

// Qualifies one input: with filtering on it counts as active only after it
// has stayed active for the whole response time; any drop restarts the count.
module eio_filter (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       tick_i,
    input  wire logic       en_i,
    input  wire logic [8:0] limit_i,
    input  wire logic       raw_i,
    output logic            level_o
);
    logic [8:0] cnt_r;
    logic [8:0] cnt_nxt;

    // Saturating millisecond count while the input is held
    always_comb begin
        cnt_nxt = cnt_r;
        if (!raw_i) begin
            cnt_nxt = 9'h000;
        end else if (tick_i && cnt_r < limit_i) begin
            cnt_nxt = cnt_r + 9'h001;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_r <= 9'h000;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

    assign level_o = raw_i && (!en_i || cnt_r >= limit_i);

endmodule : eio_filter
`default_nettype wire

// ---- eio_top.sv ----
`timescale 1ns/1ps
`default_nettype none

module eio_top #(
    parameter int unsigned MS_CYCLES = eio_pkg::CYC_PER_TICK,
    parameter int unsigned MAX_UNITS = 2
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        measure_trigger_in_i,
    input  wire logic        print_request_in_i,
    input  wire logic        zero_adjust_in_i,
    input  wire logic [7:0]  aux_in_i,
    input  wire logic [1:0]  scanner_units_i,
    input  wire logic        meas_done_i,
    input  wire logic [7:0]  judge_i,
    output logic             end_of_measurement_out_o,
    output logic      [7:0]  judge_out_o,
    output logic             trigger_event_o,
    output logic             print_event_o,
    output logic             zero_adjust_event_o,
    output logic             external_trigger_source_o,
    output logic             scanner_terminal_select_o,
    output logic             memory_enable_o
);
    localparam int TW = $clog2(MS_CYCLES + 1);

    // Byte-lane merge of a write into a register image
    function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] dat,
                                           input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) r[8*b +: 8] = dat[8*b +: 8];
        end
        return r;
    endfunction : wmerge

    // Clamp a setting into its legal range
    function automatic logic [8:0] clamp(input logic [8:0] v, input logic [8:0] lo,
                                         input logic [8:0] hi);
        if (v < lo) return lo;
        if (v > hi) return hi;
        return v;
    endfunction : clamp

    // Millisecond tick; a long count, so a parameter lets simulation shorten it
    logic [TW-1:0] tick_cnt_r;
    logic [TW-1:0] tick_cnt_nxt;
    logic          ms_tick;

    assign ms_tick = (tick_cnt_r == TW'(MS_CYCLES - 1));

    always_comb begin
        tick_cnt_nxt = ms_tick ? '0 : tick_cnt_r + TW'(1);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tick_cnt_r <= '0;
        end else begin
            tick_cnt_r <= tick_cnt_nxt;
        end
    end

    // Register file state
    eio_pkg::eio_ctrl_t ctrl_r;
    eio_pkg::eio_ctrl_t ctrl_nxt;
    logic [8:0]         filt_ms_r;
    logic [8:0]         filt_ms_nxt;
    logic [6:0]         pulse_ms_r;
    logic [6:0]         pulse_ms_nxt;
    logic [8:0]         test_r;
    logic [8:0]         test_nxt;
    logic [31:0]        rdat_nxt;
    logic               ack_nxt;
    logic               wr_stb;
    logic [31:0]        status;
    logic [31:0]        wimg;
    logic               measure_trigger_in_lvl;
    logic               print_lvl;
    logic               eom_r;
    logic               ext_src;

    // Classic single cycle: ack one cycle after the strobe, dropped the next
    assign wr_stb = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;

    // Scan only counts when at least one unit is fitted
    // forced external source
    assign ext_src = ctrl_r.measure_trigger_in_ext ||
                     (ctrl_r.term_scanner && ctrl_r.scan_mode != eio_pkg::SCAN_OFF);

    assign status = {12'h000, aux_in_i, 3'h0, scanner_terminal_select_o, memory_enable_o,
                     ext_src, print_lvl, measure_trigger_in_lvl, eom_r, zero_adjust_in_i,
                     print_request_in_i, measure_trigger_in_i};

    // Register writes, range clamps and terminal interlocks
    always_comb begin
        ctrl_nxt     = ctrl_r;
        filt_ms_nxt  = filt_ms_r;
        pulse_ms_nxt = pulse_ms_r;
        test_nxt     = test_r;
        wimg         = 32'h0000_0000;
        if (wr_stb) begin
            case (wb_adr_i)
                eio_pkg::OFS_CTRL: begin
                    wimg     = wmerge({20'h00000, ctrl_r}, wb_dat_i, wb_sel_i);
                    ctrl_nxt = eio_pkg::eio_ctrl_t'(wimg[11:0]);
                end
                eio_pkg::OFS_FILT: begin
                    wimg        = wmerge({23'h000000, filt_ms_r}, wb_dat_i, wb_sel_i);
                    filt_ms_nxt = (wimg[31:9] != 23'h000000) ? eio_pkg::FILT_MAX_MS :
                                  clamp(wimg[8:0], eio_pkg::FILT_MIN_MS, eio_pkg::FILT_MAX_MS);
                end
                eio_pkg::OFS_PULSE: begin
                    wimg         = wmerge({25'h0000000, pulse_ms_r}, wb_dat_i, wb_sel_i);
                    pulse_ms_nxt = (wimg[31:7] != 25'h0000000) ? eio_pkg::PULSE_MAX_MS :
                                   7'(clamp({2'h0, wimg[6:0]}, {2'h0, eio_pkg::PULSE_MIN_MS},
                                            {2'h0, eio_pkg::PULSE_MAX_MS}));
                end
                eio_pkg::OFS_TEST: begin
                    wimg     = wmerge({23'h000000, test_r}, wb_dat_i, wb_sel_i);
                    test_nxt = wimg[8:0];
                end
                default: begin
                    wimg = 32'h0000_0000;
                end
            endcase
        end
        // No unit fitted, or more than MAX_UNITS: scanner terminals cannot be chosen
        if (scanner_units_i == 2'h0 || 32'(scanner_units_i) > MAX_UNITS) begin
            ctrl_nxt.term_scanner = 1'b0;
        end
        if (ctrl_nxt.stats_en || ctrl_nxt.sort_en) begin
            ctrl_nxt.term_scanner = 1'b0;
        end
        if (ctrl_nxt.term_scanner) begin
            ctrl_nxt.memory_en = 1'b0;
        end
    end

    // Read data and acknowledge; unmapped reads give zero, writes are dropped
    always_comb begin
        ack_nxt  = wb_cyc_i && wb_stb_i && !wb_ack_o;
        rdat_nxt = 32'h0000_0000;
        case (wb_adr_i)
            eio_pkg::OFS_CTRL:   rdat_nxt = {20'h00000, ctrl_r};
            eio_pkg::OFS_FILT:   rdat_nxt = {23'h000000, filt_ms_r};
            eio_pkg::OFS_PULSE:  rdat_nxt = {25'h0000000, pulse_ms_r};
            eio_pkg::OFS_TEST:   rdat_nxt = {23'h000000, test_r};
            eio_pkg::OFS_STATUS: rdat_nxt = status;
            default:             rdat_nxt = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_r     <= eio_pkg::CTRL_RST;
            filt_ms_r  <= eio_pkg::FILT_RST_MS;
            pulse_ms_r <= eio_pkg::PULSE_RST_MS;
            test_r     <= 9'h000;
            wb_ack_o   <= 1'b0;
            wb_dat_o   <= 32'h0000_0000;
        end else begin
            ctrl_r     <= ctrl_nxt;
            filt_ms_r  <= filt_ms_nxt;
            pulse_ms_r <= pulse_ms_nxt;
            test_r     <= test_nxt;
            wb_ack_o   <= ack_nxt;
            wb_dat_o   <= rdat_nxt;
        end
    end

    eio_filter u_measure_trigger_in_filt (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .tick_i  (ms_tick),
        .en_i    (ctrl_r.filter_en),
        .limit_i (filt_ms_r),
        .raw_i   (measure_trigger_in_i),
        .level_o (measure_trigger_in_lvl)
    );

    eio_filter u_print_filt (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .tick_i  (ms_tick),
        .en_i    (ctrl_r.filter_en),
        .limit_i (filt_ms_r),
        .raw_i   (print_request_in_i),
        .level_o (print_lvl)
    );

    // Edge detection on the qualified trigger and print levels and the raw zero adjust input
    logic measure_trigger_in_d_r;
    logic print_d_r;
    logic zadj_d_r;
    logic measure_trigger_in_edge;
    logic print_edge;
    logic zadj_edge;

    assign measure_trigger_in_edge  = ctrl_r.measure_trigger_in_off_edge ? (measure_trigger_in_d_r && !measure_trigger_in_lvl) : (!measure_trigger_in_d_r && measure_trigger_in_lvl);
    assign print_edge = !print_d_r && print_lvl;
    assign zadj_edge  = !zadj_d_r && zero_adjust_in_i;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            measure_trigger_in_d_r  <= 1'b0;
            print_d_r <= 1'b0;
            zadj_d_r  <= 1'b0;
        end else begin
            measure_trigger_in_d_r  <= measure_trigger_in_lvl;
            print_d_r <= print_lvl;
            zadj_d_r  <= zero_adjust_in_i;
        end
    end

    // Events are suppressed in test mode so the operator can exercise pins
    assign trigger_event_o     = measure_trigger_in_edge && ext_src && !ctrl_r.test_mode;
    assign print_event_o       = print_edge && !ctrl_r.test_mode;
    assign zero_adjust_event_o = zadj_edge && !ctrl_r.test_mode;

    // End-of-measurement shaping
    eio_pkg::eio_eom_state_t eom_st_r;
    eio_pkg::eio_eom_state_t eom_st_nxt;
    logic [6:0]              eom_cnt_r;
    logic [6:0]              eom_cnt_nxt;

    always_comb begin
        eom_st_nxt  = eom_st_r;
        eom_cnt_nxt = eom_cnt_r;
        case (eom_st_r)
            eio_pkg::EOM_HOLD: begin
                if (measure_trigger_in_edge || zadj_edge) begin
                    eom_st_nxt = eio_pkg::EOM_IDLE;
                end
            end
            eio_pkg::EOM_PULSE: begin
                if (ms_tick) begin
                    eom_cnt_nxt = eom_cnt_r - 7'd1;
                    if (eom_cnt_r == 7'd1) begin
                        eom_st_nxt = eio_pkg::EOM_IDLE;
                    end
                end
            end
            default: begin
                eom_st_nxt = eio_pkg::EOM_IDLE;
            end
        endcase
        // A completion restarts the output when the source is external or autocal is set; it wins over a release
        if (meas_done_i) begin
            if (ext_src) begin
                eom_st_nxt  = ctrl_r.eom_pulse ? eio_pkg::EOM_PULSE : eio_pkg::EOM_HOLD;
                eom_cnt_nxt = pulse_ms_r;
            end else if (ctrl_r.autocal) begin
                eom_st_nxt  = eio_pkg::EOM_PULSE;
                eom_cnt_nxt = eio_pkg::AUTOCAL_MS;
            end else begin
                eom_st_nxt  = eio_pkg::EOM_IDLE;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            eom_st_r    <= eio_pkg::EOM_IDLE;
            eom_cnt_r   <= 7'd0;
            eom_r       <= 1'b0;
            judge_out_o <= 8'h00;
        end else begin
            eom_st_r  <= eom_st_nxt;
            eom_cnt_r <= eom_cnt_nxt;
            eom_r       <= ctrl_r.test_mode ? test_r[8] : (eom_st_nxt != eio_pkg::EOM_IDLE);
            judge_out_o <= ctrl_r.test_mode ? test_r[7:0] : judge_i;
        end
    end

    assign end_of_measurement_out_o  = eom_r;
    assign external_trigger_source_o = ext_src;
    assign scanner_terminal_select_o = ctrl_r.term_scanner;
    assign memory_enable_o           = ctrl_r.memory_en;

endmodule : eio_top
`default_nettype wire

// ---- eio_top_assertions.sv ----
`timescale 1ns/1ps
`default_nettype none

// Port-level timing checks for the control port block
module eio_top_checker (
    input wire logic       clk_i,
    input wire logic       rst_i,
    input wire logic       wb_cyc_i,
    input wire logic       wb_stb_i,
    input wire logic       wb_ack_o,
    input wire logic       print_request_in_i,
    input wire logic       zero_adjust_in_i,
    input wire logic [1:0] scanner_units_i,
    input wire logic       meas_done_i,
    input wire logic       end_of_measurement_out_o,
    input wire logic       trigger_event_o,
    input wire logic       print_event_o,
    input wire logic       zero_adjust_event_o,
    input wire logic       external_trigger_source_o,
    input wire logic       scanner_terminal_select_o,
    input wire logic       memory_enable_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // Bus answer one cycle after a request, never held
    a_ack_answers_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack missing after request");
    a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
    a_ack_needs_req: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    a_eom_after_done: assert property (meas_done_i && external_trigger_source_o |=>
        end_of_measurement_out_o) else $error("eom not raised");
    a_scan_mem_off: assert property (scanner_terminal_select_o |-> !memory_enable_o)
        else $error("memory on with scanner terminals");
    a_units_gate_term: assert property ((scanner_units_i inside {2'h0, 2'h3}) [*2] |->
        !scanner_terminal_select_o) else $error("scanner terminals without units");
    a_print_held_high: assert property (print_event_o |-> print_request_in_i)
        else $error("print event with input low");
    a_zadj_rise_only: assert property (zero_adjust_event_o |->
        zero_adjust_in_i && !$past(zero_adjust_in_i)) else $error("zero adjust not an edge");
    a_measure_trigger_in_ext_only: assert property (trigger_event_o |-> external_trigger_source_o)
        else $error("trigger event on internal source");

    // Main scenarios
    c_bus: cover property (wb_ack_o);
    c_measure_trigger_in: cover property (trigger_event_o);
    c_eom: cover property ($rose(end_of_measurement_out_o));
endmodule : eio_top_checker

bind eio_top eio_top_checker u_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o,
    .print_request_in_i, .zero_adjust_in_i, .scanner_units_i, .meas_done_i,
    .end_of_measurement_out_o, .trigger_event_o, .print_event_o, .zero_adjust_event_o,
    .external_trigger_source_o, .scanner_terminal_select_o, .memory_enable_o);

`default_nettype wire

// ---- eio_ctl_model.sv ----
`timescale 1ns/1ps
`default_nettype none

// Outside controller: holds the trigger active for a chosen number of cycles
module eio_ctl_model (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        req_i,
    input  wire logic [15:0] len_i,
    output logic             measure_trigger_in_o
);
    logic [15:0] cnt_r;

    always_ff @(posedge clk_i) begin
        if (rst_i) cnt_r <= 16'h0000;
        else if (req_i) cnt_r <= len_i;
        else if (cnt_r != 16'h0000) cnt_r <= cnt_r - 16'h0001;
    end
    assign measure_trigger_in_o = (cnt_r != 16'h0000); // Released input goes inactive
endmodule : eio_ctl_model

`default_nettype wire

// ---- eio_top_bench.sv ----
`timescale 1ns/1ps
`default_nettype none

module eio_top_bench;
    logic        clk_i, rst_i, cyc, stb, we, measure_trigger_in, mtrig, prn, zadj, done, req;
    logic        ack, end_of_measurement_out, tev, pev, zev, external_trigger_source, tsel, mem;
    logic [7:0]  adr, aux, jin, jout;
    logic [3:0]  sel;
    logic [1:0]  units;
    logic [15:0] len;
    logic [31:0] dat, q, rdat;
    int          errors, compares, nev, npe, nze, w;

    // Short ms so filter and pulse counts stay small
    eio_top #(.MS_CYCLES(10)) u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .measure_trigger_in_i(measure_trigger_in | mtrig),
        .print_request_in_i(prn), .zero_adjust_in_i(zadj), .aux_in_i(aux),
        .scanner_units_i(units), .meas_done_i(done), .judge_i(jin),
        .end_of_measurement_out_o(end_of_measurement_out), .judge_out_o(jout), .trigger_event_o(tev),
        .print_event_o(pev), .zero_adjust_event_o(zev), .external_trigger_source_o(external_trigger_source),
        .scanner_terminal_select_o(tsel), .memory_enable_o(mem));
    eio_ctl_model u_ctl (.clk_i(clk_i), .rst_i(rst_i), .req_i(req), .len_i(len),
        .measure_trigger_in_o(mtrig));

    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end
    // Count event pulses as the design reports them
    always @(posedge clk_i) begin
        if (tev === 1'b1) nev++;
        if (pev === 1'b1) npe++;
        if (zev === 1'b1) nze++;
    end

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            errors++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // Classic single cycle; waits for ack, bounded
    task automatic bus(input logic w_en, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_i);
        {cyc, stb, we, adr, dat} <= {2'b11, w_en, a, d};
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 50);
        if (n >= 50) errors++;
        q = rdat;
        {cyc, stb} <= 2'b00;
    endtask : bus
    task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(nm, e, q);
    endtask : rdchk
    // One finished measurement, then count the output high cycles
    task automatic pulse_w();
        @(posedge clk_i) done <= 1'b1;
        @(posedge clk_i) done <= 1'b0;
        w = 0;
        repeat (1200) begin
            @(posedge clk_i);
            if (end_of_measurement_out === 1'b1) w++;
        end
    endtask : pulse_w
    task automatic hold_measure_trigger_in(input logic [15:0] n);
        @(posedge clk_i) {req, len} <= {1'b1, n};
        @(posedge clk_i) req <= 1'b0;
        repeat (900) @(posedge clk_i);
    endtask : hold_measure_trigger_in
    task automatic end_sim();
        $display("errors %0d compares %0d", errors, compares);
        if (errors == 0 && compares > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : end_sim

    // Watchdog well past the roughly 10k cycles of the tests
    initial begin
        #(100 * 60000);
        errors++;
        end_sim();
    end

    initial begin
        {rst_i, cyc, stb, we, measure_trigger_in, prn, zadj, done, req} = 9'h100;
        {adr, aux, jin, sel, units, len, dat} = {8'h00, 8'h00, 8'h3C, 4'hF, 2'h2, 16'h0, 32'h0};
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        rdchk("ctrl_rst", eio_pkg::OFS_CTRL, 32'h0); // defaults
        rdchk("filt_rst", eio_pkg::OFS_FILT, 32'h32); // defaults
        rdchk("pulse_rst", eio_pkg::OFS_PULSE, 32'h5); // defaults
        rdchk("unmapped", 8'h20, 32'h0);
        bus(1'b1, eio_pkg::OFS_FILT, 32'hA);
        rdchk("filt_lo", eio_pkg::OFS_FILT, 32'h32); // range
        bus(1'b1, eio_pkg::OFS_FILT, 32'h3FF);
        rdchk("filt_hi", eio_pkg::OFS_FILT, 32'h1F4); // range
        bus(1'b1, eio_pkg::OFS_PULSE, 32'h0);
        rdchk("pulse_lo", eio_pkg::OFS_PULSE, 32'h1); // range
        bus(1'b1, eio_pkg::OFS_PULSE, 32'hC8);
        rdchk("pulse_hi", eio_pkg::OFS_PULSE, 32'h64); // range
        bus(1'b1, eio_pkg::OFS_CTRL, 32'hC);
        bus(1'b1, eio_pkg::OFS_PULSE, 32'h3);
        pulse_w();
        chk("pulse_width", 32'h1, 32'(w >= 19 && w <= 31));
        bus(1'b1, eio_pkg::OFS_PULSE, 32'h64);
        for (int i = 0; i < 2; i++) begin
            bus(1'b1, eio_pkg::OFS_CTRL, i ? 32'h14 : 32'h10);
            pulse_w();
            chk("autocal_width", 32'h1, 32'(w >= 39 && w <= 51));
            bus(1'b1, eio_pkg::OFS_CTRL, i ? 32'h4 : 32'h0);
            pulse_w();
            chk("manual_width", 32'h0, 32'(w));
        end
        bus(1'b1, eio_pkg::OFS_CTRL, 32'h8);
        pulse_w();
        chk("hold_level", 32'h1, 32'(end_of_measurement_out));
        @(posedge clk_i) measure_trigger_in <= 1'b1;
        repeat (3) @(posedge clk_i);
        chk("hold_measure_trigger_in_release", 32'h0, 32'(end_of_measurement_out));
        measure_trigger_in <= 1'b0;
        pulse_w();
        @(posedge clk_i) zadj <= 1'b1;
        repeat (3) @(posedge clk_i);
        chk("hold_zadj_release", 32'h0, 32'(end_of_measurement_out));
        chk("zadj_event", 32'h1, 32'(nze));
        zadj <= 1'b0;
        bus(1'b1, eio_pkg::OFS_CTRL, 32'hA);
        nev = 0;
        npe = 0;
        {measure_trigger_in, prn} <= 2'b11;
        repeat (3) @(posedge clk_i);
        chk("off_edge_rise", 32'h0, 32'(nev));
        {measure_trigger_in, prn} <= 2'b00;
        repeat (3) @(posedge clk_i);
        chk("off_edge_fall", 32'h1, 32'(nev));
        chk("print_event", 32'h1, 32'(npe));
        bus(1'b1, eio_pkg::OFS_CTRL, 32'h9);
        bus(1'b1, eio_pkg::OFS_FILT, 32'h32);
        nev = 0;
        hold_measure_trigger_in(16'd300);
        chk("filter_short", 32'h0, 32'(nev));
        hold_measure_trigger_in(16'd700);
        chk("filter_long", 32'h1, 32'(nev));
        {aux, prn} <= {8'h5A, 1'b1};
        bus(1'b1, eio_pkg::OFS_CTRL, 32'h20);
        bus(1'b1, eio_pkg::OFS_TEST, 32'h1A5);
        @(posedge clk_i);
        chk("test_outputs", 32'h1A5, {end_of_measurement_out, jout});
        rdchk("test_status", eio_pkg::OFS_STATUS, 32'h5A02A);
        prn <= 1'b0;
        bus(1'b1, eio_pkg::OFS_CTRL, 32'hC0);
        rdchk("scan_mem", eio_pkg::OFS_CTRL, 32'h40);
        chk("mem_pin", 32'h0, 32'(mem));
        chk("judge_pass", 32'h3C, 32'(jout));
        bus(1'b1, eio_pkg::OFS_CTRL, 32'h1C0);
        rdchk("stats_front", eio_pkg::OFS_CTRL, 32'h180);
        bus(1'b1, eio_pkg::OFS_CTRL, 32'h2C0);
        rdchk("sort_front", eio_pkg::OFS_CTRL, 32'h280);
        bus(1'b1, eio_pkg::OFS_CTRL, 32'h440);
        chk("auto_ext", 32'h3, {tsel, external_trigger_source});
        bus(1'b1, eio_pkg::OFS_CTRL, 32'h840);
        chk("step_ext", 32'h3, {tsel, external_trigger_source});
        bus(1'b1, eio_pkg::OFS_CTRL, 32'h40);
        chk("no_scan_int", 32'h2, {tsel, external_trigger_source});
        units <= 2'h0;
        bus(1'b1, eio_pkg::OFS_CTRL, 32'h40);
        chk("no_units", 32'h0, 32'(tsel));
        units <= 2'h3;
        bus(1'b1, eio_pkg::OFS_CTRL, 32'h40);
        chk("three_units", 32'h0, 32'(tsel));
        end_sim();
    end
endmodule : eio_top_bench

`default_nettype wire
